// ==== include/pacr_defines.vh ====
// Register map, field positions and reset values of the port register bank.
// Assumes inclusion by the bank module, its properties and its bench; holds definitions alone.
`ifndef PACR_DEFINES_VH
`define PACR_DEFINES_VH

`define PACR_ADDR_ADV       5'h04
`define PACR_ADDR_LP_BASE   5'h05
`define PACR_ADDR_EXP       5'h06
`define PACR_ADDR_NP_TX     5'h07
`define PACR_ADDR_LP_NP     5'h08
`define PACR_ADDR_PORT_CFG  5'h10
`define PACR_ADDR_QSTAT     5'h11

// Writable masks; bits outside read as zero
`define PACR_ADV_WMASK      16'hAFFF
`define PACR_NP_TX_WMASK    16'hBFFF
`define PACR_CFG_WMASK      16'h7567

// Fixed parts of reset values; strap bits are merged into the advertise and config values
`define PACR_ADV_RST        16'h8001
`define PACR_NP_TX_RST      16'h2001
`define PACR_CFG_RST        16'h0104

`define PACR_ADV_PAUSE      10
`define PACR_ADV_ABIL_LO    5
`define PACR_ADV_ABIL_HI    8
`define PACR_SEL_HI         4
`define PACR_SEL_RSVD_LO    5'h00
`define PACR_SEL_RSVD_HI    5'h1F

`define PACR_CFG_FORCE_LINK 14
`define PACR_CFG_TX_DIS     13
`define PACR_CFG_SCR_BYP    12
`define PACR_CFG_JAB_DIS    10
`define PACR_CFG_LPBK_DIS   8
`define PACR_CFG_FIFO_BIG   6
`define PACR_CFG_PRE_EN     5
`define PACR_CFG_FEF_EN     2
`define PACR_CFG_ALT_NP     1
`define PACR_CFG_FIBER      0

`define PACR_EXP_BASE_PAGE  5
`define PACR_EXP_PD_FAULT   4
`define PACR_EXP_LP_NP_ABLE 3
`define PACR_EXP_NP_ABLE    2
`define PACR_EXP_PAGE_RX    1
`define PACR_EXP_LP_AN_ABLE 0

`define PACR_QS_100_MODE    14
`define PACR_QS_TX_ACTIVE   13

// Strap vector layout: fiber, pause, four ability bits
`define PACR_STRAP_W        6
`define PACR_STRAP_FIBER    5
`define PACR_STRAP_PAUSE    4
`define PACR_STRAP_ABIL_HI  3

`endif

// ==== logic/pacr_port_regs.v ====
// Per-port auto-negotiation and port configuration register bank.
// Assumes a management frame decoder on clk_in drives the access port,
// and the negotiation engine on clk_in drives the page and status inputs.
//
// Summary of operation
// - Next-page ability bit writable, resets one
// - Pause ability writable, reset from strap
// - Four ability bits writable, reset from straps
// - T4 advertise bit writable, resets zero
// - Selector resets 802.3; reserved codes refused
// - Partner base page read-only, resets zero
// - Base-page status shown only when alternate
// - Parallel fault latches; next-page-able always one
// - Page-received latches, clears on read/alternate
// - Next-page transmit fields writable, documented resets
// - Partner next page read-only, resets zero
// - Addresses nine, ten, fifteen unimplemented
// - Force link pass control bit
// - Twisted-pair transmitter disable bit
// - Scrambler and descrambler bypass bit
// - Jabber disable bit
// - Half-duplex loopback disable, resets one
// - Receive FIFO size select bit
// - Preamble enable moves RX_DV rise
// - Far-end-fault transmit enable, resets one
// - Fiber select reset from strap pin
// - Quick status mode and transmit bits
`timescale 1ns/10ps
`include "pacr_defines.vh"

module pacr_port_regs (
    input  wire        clk_in,                  // 250 MHz clock
    input  wire        srst_in,                 // Synchronous reset, high
    input  wire [4:0]  mgmt_addr_in,            // Register address
    input  wire        mgmt_wr_in,              // Write strobe, one cycle
    input  wire [15:0] mgmt_wdata_in,           // Write data
    input  wire        mgmt_rd_in,              // Read strobe, one cycle
    output reg  [15:0] mgmt_rdata_out,          // Read data, registered
    output reg         mgmt_rvalid_out,         // Read data valid pulse
    input  wire        fiber_strap_pin_in,      // Fiber strap pin
    input  wire        pause_strap_in,          // Pause strap pin
    input  wire [3:0]  ability_strap_in,        // Ability strap pins
    input  wire        base_page_rx_in,         // Base page received pulse
    input  wire        next_page_rx_in,         // Next page received pulse
    input  wire [15:0] partner_word_in,         // Received code word
    input  wire        parallel_fault_in,       // Parallel detect fault pulse
    input  wire        base_page_var_in,        // Engine base_page variable
    input  wire        mr_page_rx_in,           // Engine mr_page_rx variable
    input  wire        transmit_disable_var_in, // Engine transmit_disable
    input  wire        partner_np_able_in,      // Partner next page able
    input  wire        partner_an_able_in,      // Partner negotiation able
    input  wire        mode_100tx_in,           // Operating in 100BASE-TX
    input  wire        tx_active_in,            // Transmitting a packet
    output wire [15:0] adv_word_out,            // Advertised base page
    output wire [15:0] next_page_word_out,      // Next page to transmit
    output wire        force_link_pass_out,     // Force link pass state
    output wire        tp_tx_disable_out,       // Disable TP transmitter
    output wire        scrambler_bypass_out,    // Bypass scrambler
    output wire        jabber_disable_out,      // Disable jabber
    output wire        tp_loopback_disable_out, // Disable TP loopback
    output wire        fifo_large_out,          // 8 KB receive FIFO
    output wire        preamble_enable_out,     // RX_DV with preamble
    output wire        far_end_fault_en_out,    // Far-end fault enable
    output wire        alt_next_page_enable_out,// Alternate next page
    output wire        fiber_mode_out           // Fiber mode selected
);

    // Strap synchroniser; stage one feeds stage two only
    reg  [`PACR_STRAP_W-1:0] strap_s1_r;
    reg  [`PACR_STRAP_W-1:0] strap_s2_r;
    reg  [`PACR_STRAP_W-1:0] strap_s3_r;
    reg  [`PACR_STRAP_W-1:0] strap_f_r;
    wire [`PACR_STRAP_W-1:0] strap_raw;

    reg  [15:0] adv_r;
    reg  [15:0] np_tx_r;
    reg  [15:0] cfg_r;
    reg  [15:0] lp_base_r;
    reg  [15:0] lp_np_r;
    reg         pd_fault_r;
    reg         page_rx_r;

    reg  [15:0] adv_nxt;
    reg  [15:0] np_tx_nxt;
    reg  [15:0] cfg_nxt;
    reg  [15:0] lp_base_nxt;
    reg  [15:0] lp_np_nxt;
    reg         pd_fault_nxt;
    reg         page_rx_nxt;
    reg  [15:0] rd_nxt;
    wire        wr_adv;
    wire        wr_np;
    wire        wr_cfg;
    wire        rd_exp;
    wire        page_rx_set;
    wire        page_rx_clr;
    wire        pd_fault_clr;
    reg  [15:0] exp_word;
    reg  [15:0] qstat_word;
    reg  [15:0] adv_strap_rst;
    reg  [15:0] cfg_strap_rst;

    function addr_hit;
        input [4:0] addr;
        input [4:0] target;
        begin
            addr_hit = (addr == target);
        end
    endfunction

    function sel_reserved;
        input [4:0] sel;
        begin
            sel_reserved = (sel == `PACR_SEL_RSVD_LO) || (sel == `PACR_SEL_RSVD_HI);
        end
    endfunction

    assign strap_raw = {fiber_strap_pin_in, pause_strap_in, ability_strap_in};

    // Straps have no reset; the filter settles while reset is held
    // A strap change counts once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < `PACR_STRAP_W; gi = gi + 1) begin : g_strap
            always @(posedge clk_in) begin
                strap_s1_r[gi] <= strap_raw[gi];
                strap_s2_r[gi] <= strap_s1_r[gi];
                strap_s3_r[gi] <= strap_s2_r[gi];
                if (strap_s2_r[gi] == strap_s3_r[gi]) begin
                    strap_f_r[gi] <= strap_s3_r[gi];
                end
            end
        end
    endgenerate

    assign wr_adv = mgmt_wr_in && addr_hit(mgmt_addr_in, `PACR_ADDR_ADV);
    assign wr_np  = mgmt_wr_in && addr_hit(mgmt_addr_in, `PACR_ADDR_NP_TX);
    assign wr_cfg = mgmt_wr_in && addr_hit(mgmt_addr_in, `PACR_ADDR_PORT_CFG);
    assign rd_exp = mgmt_rd_in && addr_hit(mgmt_addr_in, `PACR_ADDR_EXP);

    always @* begin
        adv_strap_rst                                      = `PACR_ADV_RST;
        adv_strap_rst[`PACR_ADV_PAUSE]                     = strap_f_r[`PACR_STRAP_PAUSE];
        adv_strap_rst[`PACR_ADV_ABIL_HI:`PACR_ADV_ABIL_LO] = strap_f_r[`PACR_STRAP_ABIL_HI:0];
    end

    always @* begin
        cfg_strap_rst                  = `PACR_CFG_RST;
        cfg_strap_rst[`PACR_CFG_FIBER] = strap_f_r[`PACR_STRAP_FIBER];
    end

    // reserved selector write keeps old code
    always @* begin
        adv_nxt = adv_r;
        if (wr_adv) begin
            adv_nxt = mgmt_wdata_in & `PACR_ADV_WMASK;
            if (sel_reserved(mgmt_wdata_in[`PACR_SEL_HI:0])) begin
                adv_nxt[`PACR_SEL_HI:0] = adv_r[`PACR_SEL_HI:0];
            end
        end
    end

    always @* begin
        np_tx_nxt = np_tx_r;
        if (wr_np) begin
            np_tx_nxt = mgmt_wdata_in & `PACR_NP_TX_WMASK;
        end
    end

    always @* begin
        cfg_nxt = cfg_r;
        if (wr_cfg) begin
            cfg_nxt = mgmt_wdata_in & `PACR_CFG_WMASK;
        end
    end

    always @(posedge clk_in) begin
        if (srst_in) begin
            adv_r <= adv_strap_rst;
        end else begin
            adv_r <= adv_nxt;
        end
    end

    always @(posedge clk_in) begin
        if (srst_in) begin
            np_tx_r <= `PACR_NP_TX_RST;
        end else begin
            np_tx_r <= np_tx_nxt;
        end
    end

    // Loads the filtered strap on every reset cycle
    always @(posedge clk_in) begin
        if (srst_in) begin
            cfg_r <= cfg_strap_rst;
        end else begin
            cfg_r <= cfg_nxt;
        end
    end

    always @* begin
        lp_base_nxt = lp_base_r;
        lp_np_nxt   = lp_np_r;
        if (base_page_rx_in) begin
            lp_base_nxt = partner_word_in;
        end
        if (next_page_rx_in) begin
            lp_np_nxt = partner_word_in;
        end
    end

    always @(posedge clk_in) begin
        if (srst_in) begin
            lp_base_r <= 16'h0000;
            lp_np_r   <= 16'h0000;
        end else begin
            lp_base_r <= lp_base_nxt;
            lp_np_r   <= lp_np_nxt;
        end
    end

    assign page_rx_set  = base_page_rx_in || next_page_rx_in;
    assign page_rx_clr  = rd_exp || (cfg_r[`PACR_CFG_ALT_NP] && (!mr_page_rx_in || transmit_disable_var_in));
    assign pd_fault_clr = rd_exp;

    // fault latches until read; set wins
    always @* begin
        pd_fault_nxt = pd_fault_r;
        page_rx_nxt  = page_rx_r;
        if (pd_fault_clr) begin
            pd_fault_nxt = 1'b0;
        end
        if (parallel_fault_in) begin
            pd_fault_nxt = 1'b1;
        end
        if (page_rx_clr) begin
            page_rx_nxt = 1'b0;
        end
        if (page_rx_set) begin
            page_rx_nxt = 1'b1;
        end
    end

    always @(posedge clk_in) begin
        if (srst_in) begin
            pd_fault_r <= 1'b0;
            page_rx_r  <= 1'b0;
        end else begin
            pd_fault_r <= pd_fault_nxt;
            page_rx_r  <= page_rx_nxt;
        end
    end

    // base page only when alternate on
    always @* begin
        exp_word                       = 16'h0000;
        exp_word[`PACR_EXP_BASE_PAGE]  = cfg_r[`PACR_CFG_ALT_NP] & base_page_var_in;
        exp_word[`PACR_EXP_PD_FAULT]   = pd_fault_r;
        exp_word[`PACR_EXP_LP_NP_ABLE] = partner_np_able_in;
        exp_word[`PACR_EXP_NP_ABLE]    = 1'b1;
        exp_word[`PACR_EXP_PAGE_RX]    = page_rx_r;
        exp_word[`PACR_EXP_LP_AN_ABLE] = partner_an_able_in;
    end

    always @* begin
        qstat_word                     = 16'h0000;
        qstat_word[`PACR_QS_100_MODE]  = mode_100tx_in;
        qstat_word[`PACR_QS_TX_ACTIVE] = tx_active_in;
    end

    always @* begin
        case (mgmt_addr_in)
            `PACR_ADDR_ADV:      rd_nxt = adv_r;
            `PACR_ADDR_LP_BASE:  rd_nxt = lp_base_r;
            `PACR_ADDR_EXP:      rd_nxt = exp_word;
            `PACR_ADDR_NP_TX:    rd_nxt = np_tx_r;
            `PACR_ADDR_LP_NP:    rd_nxt = lp_np_r;
            `PACR_ADDR_PORT_CFG: rd_nxt = cfg_r;
            `PACR_ADDR_QSTAT:    rd_nxt = qstat_word;
            default:             rd_nxt = 16'h0000;
        endcase
    end

    always @(posedge clk_in) begin
        if (srst_in) begin
            mgmt_rvalid_out <= 1'b0;
        end else begin
            mgmt_rvalid_out <= mgmt_rd_in;
        end
    end

    // Data holds until the next read so a slow master can take it late
    always @(posedge clk_in) begin
        if (srst_in) begin
            mgmt_rdata_out <= 16'h0000;
        end else if (mgmt_rd_in) begin
            mgmt_rdata_out <= rd_nxt;
        end
    end

    assign adv_word_out       = adv_r;
    assign next_page_word_out = np_tx_r;

    assign force_link_pass_out      = cfg_r[`PACR_CFG_FORCE_LINK];
    assign tp_tx_disable_out        = cfg_r[`PACR_CFG_TX_DIS];
    assign scrambler_bypass_out     = cfg_r[`PACR_CFG_SCR_BYP];
    assign jabber_disable_out       = cfg_r[`PACR_CFG_JAB_DIS];
    assign tp_loopback_disable_out  = cfg_r[`PACR_CFG_LPBK_DIS];
    assign fifo_large_out           = cfg_r[`PACR_CFG_FIFO_BIG];
    assign preamble_enable_out      = cfg_r[`PACR_CFG_PRE_EN];
    assign far_end_fault_en_out     = cfg_r[`PACR_CFG_FEF_EN];
    assign alt_next_page_enable_out = cfg_r[`PACR_CFG_ALT_NP];
    assign fiber_mode_out           = cfg_r[`PACR_CFG_FIBER];

endmodule

// ==== sim/pacr_port_regs_properties.sv ====
// Concurrent checks on the port register bank ports.
// Assumes a bind onto pacr_port_regs from the bench top file.
`timescale 1ns/10ps
`include "pacr_defines.vh"
module pacr_port_regs_properties (
    input wire logic        clk_in,              // Clock
    input wire logic        srst_in,             // Reset
    input wire logic [4:0]  mgmt_addr_in,        // Address
    input wire logic        mgmt_wr_in,          // Write
    input wire logic [15:0] mgmt_wdata_in,       // Data
    input wire logic        mgmt_rd_in,          // Read
    input wire logic [15:0] mgmt_rdata_out,      // Read data
    input wire logic        mgmt_rvalid_out,     // Read valid
    input wire logic        mode_100tx_in,       // TX mode
    input wire logic        tx_active_in,        // Sending
    input wire logic [15:0] adv_word_out,        // Advertised
    input wire logic [15:0] next_page_word_out,  // Next page
    input wire logic        force_link_pass_out, // Force link
    input wire logic        fiber_mode_out       // Fiber
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);
    wire wr_adv = mgmt_wr_in && mgmt_addr_in == `PACR_ADDR_ADV;
    wire sel_bad = mgmt_wdata_in[4:0] == 5'h00 || mgmt_wdata_in[4:0] == 5'h1F;
    wire rd_hole = mgmt_rd_in && (mgmt_addr_in == 5'h09 || mgmt_addr_in == 5'h0A || mgmt_addr_in == 5'h0F);
    a_read_answer: assert property (mgmt_rd_in |=> mgmt_rvalid_out)
        else $error("read not answered");
    a_reset_words: assert property (disable iff (1'b0) $fell(srst_in) |->
        (adv_word_out & 16'hC21F) == 16'h8001 && next_page_word_out == 16'h2001) else $error("bad reset word");
    a_adv_write: assert property (wr_adv && !sel_bad |=> adv_word_out == ($past(mgmt_wdata_in) & 16'hAFFF))
        else $error("advert write lost");
    a_sel_kept: assert property (wr_adv && sel_bad |=> $stable(adv_word_out[4:0]))
        else $error("reserved selector taken");
    a_np_write: assert property (mgmt_wr_in && mgmt_addr_in == `PACR_ADDR_NP_TX |=>
        next_page_word_out == ($past(mgmt_wdata_in) & 16'hBFFF)) else $error("next page write lost");
    a_cfg_write: assert property (mgmt_wr_in && mgmt_addr_in == `PACR_ADDR_PORT_CFG |=>
        force_link_pass_out == $past(mgmt_wdata_in[14]) && fiber_mode_out == $past(mgmt_wdata_in[0]))
        else $error("config write lost");
    a_words_hold: assert property (!mgmt_wr_in |=> $stable(adv_word_out) && $stable(next_page_word_out))
        else $error("word changed unwritten");
    a_qstat_read: assert property (mgmt_rd_in && mgmt_addr_in == `PACR_ADDR_QSTAT |=>
        mgmt_rdata_out == {1'b0, $past(mode_100tx_in), $past(tx_active_in), 13'h0000}) else $error("bad status");
    a_absent_regs: assert property (rd_hole |=> mgmt_rdata_out == 16'h0000)
        else $error("absent register read nonzero");
    c_sel_bad: cover property (wr_adv && sel_bad);
    c_hole: cover property (rd_hole);
    c_cfg: cover property (mgmt_wr_in && mgmt_addr_in == `PACR_ADDR_PORT_CFG);
endmodule

// ==== sim/pacr_engine_model.sv ====
// Negotiation engine stand-in that delivers received pages and faults.
// Assumes the bench calls its tasks just after a falling clock edge.
`timescale 1ns/10ps
module pacr_engine_model (
    input  wire logic   clk_in,      // Clock
    output logic        base_rx_out, // Base page pulse
    output logic        next_rx_out, // Next page pulse
    output logic [15:0] word_out,    // Code word
    output logic        fault_out    // Fault pulse
);
    initial begin
        base_rx_out = 1'b0;
        next_rx_out = 1'b0;
        fault_out = 1'b0;
        word_out = 16'h5A5A;
    end
    task automatic page(input logic nxt, input logic [15:0] w);
        word_out = w;
        base_rx_out = !nxt;
        next_rx_out = nxt;
        @(negedge clk_in);
        base_rx_out = 1'b0;
        next_rx_out = 1'b0;
        // Word no longer valid, so show its inverse
        word_out = ~w;
        @(negedge clk_in);
    endtask
    task automatic fault();
        fault_out = 1'b1;
        @(negedge clk_in);
        fault_out = 1'b0;
        @(negedge clk_in);
    endtask
endmodule

// ==== sim/pacr_port_regs_tb_top.sv ====
// Self-checking bench for the port register bank.
// Assumes the engine model; status levels are driven here.
`timescale 1ns/10ps
`include "pacr_defines.vh"
module pacr_port_regs_tb_top;
    logic        clk_in = 1'b0;
    logic        srst_in = 1'b1;
    logic [4:0]  addr = 5'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [15:0] wd = 16'h0000;
    logic [6:0]  lv = 7'h00;
    logic [5:0]  strap;
    logic [31:0] seed = 32'h8D2CF3DF;
    logic [31:0] r;
    logic [15:0] d;
    logic [4:0]  holes [3] = '{5'h09, 5'h0A, 5'h0F};
    wire  [15:0] rdata, pw, adv, npw;
    wire  [9:0]  cfg;
    wire         rvalid, bp_rx, np_rx, pf;
    int          err_total = 0;
    int          n_tests = 0;
    int          cyc = 0;
    pacr_engine_model pacr_engine_model_i (.clk_in(clk_in), .base_rx_out(bp_rx), .next_rx_out(np_rx),
        .word_out(pw), .fault_out(pf));
    pacr_port_regs pacr_port_regs_i (.clk_in(clk_in), .srst_in(srst_in), .mgmt_addr_in(addr),
        .mgmt_wr_in(wr), .mgmt_wdata_in(wd), .mgmt_rd_in(rd), .mgmt_rdata_out(rdata), .mgmt_rvalid_out(rvalid),
        .fiber_strap_pin_in(strap[5]), .pause_strap_in(strap[4]), .ability_strap_in(strap[3:0]),
        .base_page_rx_in(bp_rx), .next_page_rx_in(np_rx), .partner_word_in(pw), .parallel_fault_in(pf),
        .base_page_var_in(lv[6]), .mr_page_rx_in(lv[5]), .transmit_disable_var_in(lv[4]),
        .partner_np_able_in(lv[3]), .partner_an_able_in(lv[2]), .mode_100tx_in(lv[1]), .tx_active_in(lv[0]),
        .adv_word_out(adv), .next_page_word_out(npw), .force_link_pass_out(cfg[9]), .tp_tx_disable_out(cfg[8]),
        .scrambler_bypass_out(cfg[7]), .jabber_disable_out(cfg[6]), .tp_loopback_disable_out(cfg[5]),
        .fifo_large_out(cfg[4]), .preamble_enable_out(cfg[3]), .far_end_fault_en_out(cfg[2]),
        .alt_next_page_enable_out(cfg[1]), .fiber_mode_out(cfg[0]));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [15:0] cfg_of(input logic [15:0] v);
        return {6'h00, v[14], v[13], v[12], v[10], v[8], v[6], v[5], v[2], v[1], v[0]};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [4:0] a, input logic [15:0] v);
        addr = a;
        wd = v;
        wr = 1'b1;
        @(negedge clk_in);
        wr = 1'b0;
        @(negedge clk_in);
    endtask
    // Answer stands one cycle, so it is sampled at the next falling edge
    task automatic rchk(input logic [4:0] a, input logic [15:0] e);
        addr = a;
        rd = 1'b1;
        @(negedge clk_in);
        rd = 1'b0;
        chk({15'h0000, rvalid}, 16'h0001);
        chk(rdata, e);
        @(negedge clk_in);
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        forever #2 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 4000) begin
            err_total++;
            $display("[FAIL] %0t run too long", $time);
            summarize();
        end
    end
    initial begin
        r = rnd();
        strap = r[5:0];
        repeat (6) @(negedge clk_in);
        srst_in = 1'b0;
        rchk(`PACR_ADDR_ADV, 16'h8001 | {5'h00, strap[4], 1'b0, strap[3:0], 5'h00});
        rchk(`PACR_ADDR_LP_BASE, 16'h0000);
        rchk(`PACR_ADDR_EXP, 16'h0004);
        rchk(`PACR_ADDR_NP_TX, 16'h2001);
        rchk(`PACR_ADDR_LP_NP, 16'h0000);
        rchk(`PACR_ADDR_PORT_CFG, {15'h0082, strap[5]});
        chk({6'h00, cfg}, cfg_of({15'h0082, strap[5]}));
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            d = r[15:0] ^ {11'h000, r[4:0] == 5'h00 || r[4:0] == 5'h1F, 4'h0};
            wreg(`PACR_ADDR_ADV, d);
            rchk(`PACR_ADDR_ADV, d & 16'hAFFF);
            wreg(`PACR_ADDR_NP_TX, d);
            chk(npw, d & 16'hBFFF);
            wreg(`PACR_ADDR_PORT_CFG, d);
            rchk(`PACR_ADDR_PORT_CFG, d & 16'h7567);
            chk({6'h00, cfg}, cfg_of(d));
            wreg(`PACR_ADDR_LP_BASE, d);
            rchk(`PACR_ADDR_LP_BASE, 16'h0000);
            wreg(holes[i % 3], d);
            rchk(holes[i % 3], 16'h0000);
        end
        wreg(`PACR_ADDR_ADV, 16'h8060);
        rchk(`PACR_ADDR_ADV, 16'h8060 | {11'h000, d[4:0]});
        wreg(`PACR_ADDR_ADV, 16'h041F);
        rchk(`PACR_ADDR_ADV, 16'h0400 | {11'h000, d[4:0]});
        $display("write test done");
        wreg(`PACR_ADDR_PORT_CFG, 16'h0000);
        lv = 7'h40;
        pacr_engine_model_i.page(1'b0, r[15:0]);
        rchk(`PACR_ADDR_LP_BASE, r[15:0]);
        rchk(`PACR_ADDR_EXP, 16'h0006);
        rchk(`PACR_ADDR_EXP, 16'h0004);
        pacr_engine_model_i.page(1'b1, r[31:16]);
        pacr_engine_model_i.fault();
        rchk(`PACR_ADDR_LP_NP, r[31:16]);
        rchk(`PACR_ADDR_EXP, 16'h0016);
        rchk(`PACR_ADDR_EXP, 16'h0004);
        wreg(`PACR_ADDR_PORT_CFG, 16'h0002);
        lv = 7'h6C;
        pacr_engine_model_i.page(1'b0, r[15:0]);
        rchk(`PACR_ADDR_EXP, 16'h002F);
        pacr_engine_model_i.page(1'b0, r[15:0]);
        lv = 7'h4C;
        @(negedge clk_in);
        rchk(`PACR_ADDR_EXP, 16'h002D);
        lv = 7'h6C;
        pacr_engine_model_i.page(1'b0, r[15:0]);
        lv = 7'h7C;
        @(negedge clk_in);
        rchk(`PACR_ADDR_EXP, 16'h002D);
        $display("page test done");
        r = rnd();
        lv = {5'h00, r[1:0]};
        wreg(`PACR_ADDR_QSTAT, 16'hFFFF);
        rchk(`PACR_ADDR_QSTAT, {1'b0, r[1:0], 13'h0000});
        $display("status test done");
        summarize();
    end
endmodule
bind pacr_port_regs pacr_port_regs_properties pacr_port_regs_properties_i (.clk_in(clk_in), .srst_in(srst_in),
    .mgmt_addr_in(mgmt_addr_in), .mgmt_wr_in(mgmt_wr_in), .mgmt_wdata_in(mgmt_wdata_in), .mgmt_rd_in(mgmt_rd_in),
    .mgmt_rdata_out(mgmt_rdata_out), .mgmt_rvalid_out(mgmt_rvalid_out), .mode_100tx_in(mode_100tx_in),
    .tx_active_in(tx_active_in), .adv_word_out(adv_word_out), .next_page_word_out(next_page_word_out),
    .force_link_pass_out(force_link_pass_out), .fiber_mode_out(fiber_mode_out));
